// file: rtl/sdcm_pkg.sv
// Constants for the step/direction current mode controller
//
// Operation
// - Mode 0 disables step/direction operation and the block keeps its normal internally commanded mode.
// - Mode 1 selects hold or run current only from the enable input level, with no automatic switching.
// - Mode 2 moves from hold to run current on the first step pulse.
// - Mode 2 returns to hold current once the programmed interval has passed since the last step pulse.
// - Modes 2 and 3 ignore the enable inputs for both current selection and driver stage power.
// - Mode 3 applies run current continuously whatever the step activity.
// - Mode 4 switches current automatically as mode 2 while the enable inputs turn the driver stages on or off.
// - Mode 5 holds run current as mode 3 while the enable inputs turn the driver stages on or off.
// - The mode register accepts only 0 to 5, stays readable and writable, and other values are not to be written.
package sdcm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE      = 8'hfe;
  localparam logic [7:0] ADDR_IDLE_TIME = 8'hf0;
  localparam logic [7:0] ADDR_STATUS    = 8'hf1;
  localparam int         MODE_W         = 3;
  localparam int         TIME_W         = 16;
  localparam logic [2:0] MODE_RST       = 3'h0;
  localparam logic [2:0] MODE_MAX       = 3'h5;
  localparam logic [15:0] IDLE_TIME_RST = 16'h00c8;

  // Status fields
  localparam int ST_RUN_BIT   = 0;
  localparam int ST_DRV_BIT   = 1;
  localparam int ST_SDACT_BIT = 2;

  // ----------------------------------------------------------------
  // Timing: idle interval is counted in 10 ms ticks
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 20000000;
  localparam int TICK_MS       = 10;
  localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF      = 3'h0,
    MODE_EN_SEL   = 3'h1,
    MODE_AUTO     = 3'h2,
    MODE_RUN      = 3'h3,
    MODE_AUTO_EN  = 3'h4,
    MODE_RUN_EN   = 3'h5
  } sd_mode_e;

  // Current state machine, one-hot
  typedef enum logic [1:0] {
    CUR_HOLD = 2'b01,
    CUR_RUN  = 2'b10
  } cur_state_e;

endpackage : sdcm_pkg

// file: rtl/step_dir_current_mode_ctrl.sv
// Step/direction current and driver-stage mode controller
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module step_dir_current_mode_ctrl
  import sdcm_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES  // Cycles per idle-time tick (shorten in simulation)
) (
  input  wire logic        clk,           // 20 MHz system clock
  input  wire logic        srst,          // Sync reset, active high
  input  wire logic [7:0]  reg_addr,      // Register address
  input  wire logic [15:0] reg_wdata,     // Register write data
  input  wire logic        reg_wr,        // Write strobe
  input  wire logic        reg_rd,        // Read strobe
  output logic      [15:0] reg_rdata,     // Read data, cycle after reg_rd
  input  wire logic        step_pin,      // Step input pin, asynchronous
  input  wire logic        enable_pin,    // Enable input pin, asynchronous
  input  wire logic        int_run_req,   // Internal controller run-current request
  input  wire logic        int_drv_en,    // Internal controller driver enable
  output logic             sd_active,     // Step/direction operation enabled
  output logic             run_current,   // 1 run current, 0 hold current
  output logic             drv_enable,    // Driver stages powered
  output logic             coil_enable,   // Coil outputs energised
  output logic             step_pulse     // Synchronised step rising edge pulse
);

  // ----------------------------------------------------------------
  // Pin synchronisers and tick
  // ----------------------------------------------------------------
  logic step_s;
  logic en_s;
  logic tick;

  sync2 u_sync_step (
    .clk  (clk),
    .srst (srst),
    .d    (step_pin),
    .q    (step_s)
  );

  sync2 u_sync_en (
    .clk  (clk),
    .srst (srst),
    .d    (enable_pin),
    .q    (en_s)
  );

  tick_gen #(
    .DIV (TICK_DIV)
  ) u_tick (
    .clk  (clk),
    .srst (srst),
    .tick (tick)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [MODE_W-1:0] mode_r;
  logic [TIME_W-1:0] idle_time_r;
  logic [15:0]       rdata_r;

  wire wr_mode = reg_wr && (reg_addr == ADDR_MODE);
  wire wr_idle = reg_wr && (reg_addr == ADDR_IDLE_TIME);
  // Out-of-range values are dropped so the mode always stays legal
  wire mode_ok = (reg_wdata[15:MODE_W] == '0) && (reg_wdata[MODE_W-1:0] <= MODE_MAX);

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_r      <= MODE_RST;
      idle_time_r <= IDLE_TIME_RST;
    end else begin
      if (wr_mode && mode_ok) begin
        mode_r <= reg_wdata[MODE_W-1:0];
      end
      if (wr_idle) begin
        idle_time_r <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  sd_mode_e mode;
  assign mode = sd_mode_e'(mode_r);

  wire m_off   = (mode == MODE_OFF);
  wire m_ensel = (mode == MODE_EN_SEL);
  wire m_auto  = (mode == MODE_AUTO) || (mode == MODE_AUTO_EN);
  wire m_run   = (mode == MODE_RUN) || (mode == MODE_RUN_EN);
  wire m_engate = (mode == MODE_AUTO_EN) || (mode == MODE_RUN_EN);

  // ----------------------------------------------------------------
  // Step edge and idle timer
  // ----------------------------------------------------------------
  logic step_d_r;
  logic [TIME_W-1:0] idle_cnt_r;
  cur_state_e        cur_r;
  cur_state_e        cur_nxt;

  wire step_rise = step_s && !step_d_r;
  wire timeout   = (idle_cnt_r >= idle_time_r);

  always_ff @(posedge clk) begin
    if (srst) begin
      step_d_r   <= 1'b0;
      step_pulse <= 1'b0;
    end else begin
      step_d_r   <= step_s;
      step_pulse <= step_rise;
    end
  end

  // Counter restarts on every step so the interval runs from the last one
  always_ff @(posedge clk) begin
    if (srst) begin
      idle_cnt_r <= '0;
    end else if (step_rise || cur_r != CUR_RUN) begin
      idle_cnt_r <= '0;
    end else if (tick && !timeout) begin
      idle_cnt_r <= idle_cnt_r + TIME_W'(1);
    end
  end

  always_comb begin
    cur_nxt = cur_r;
    case (cur_r)
      CUR_HOLD: begin
        if (step_rise) begin
          cur_nxt = CUR_RUN;
        end
      end
      CUR_RUN: begin
        if (!step_rise && timeout) begin
          cur_nxt = CUR_HOLD;
        end
      end
      default: cur_nxt = CUR_HOLD;
    endcase
    if (!m_auto) begin
      cur_nxt = CUR_HOLD;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cur_r <= CUR_HOLD;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------
  logic run_sel;
  logic drv_sel;

  always_comb begin
    run_sel = int_run_req;
    drv_sel = int_drv_en;
    if (m_ensel) begin
      run_sel = en_s;
      drv_sel = 1'b1;
    end else if (m_auto) begin
      run_sel = (cur_r == CUR_RUN);
      drv_sel = m_engate ? en_s : 1'b1;
    end else if (m_run) begin
      run_sel = 1'b1;
      drv_sel = m_engate ? en_s : 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sd_active   <= 1'b0;
      run_current <= 1'b0;
      drv_enable  <= 1'b0;
      coil_enable <= 1'b0;
    end else begin
      sd_active   <= !m_off;
      run_current <= run_sel;
      drv_enable  <= drv_sel;
      coil_enable <= drv_sel;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  wire [15:0] status_w = {13'h0000, sd_active, drv_enable, run_current};
  wire [15:0] rd_mux   = (reg_addr == ADDR_MODE)      ? {13'h0000, mode_r} :
                         (reg_addr == ADDR_IDLE_TIME) ? idle_time_r :
                         (reg_addr == ADDR_STATUS)    ? status_w : 16'h0000;

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata = rdata_r;

endmodule : step_dir_current_mode_ctrl
`default_nettype wire

// file: rtl/sync2.sv
// Two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module sync2 (
  input  wire logic clk,   // System clock
  input  wire logic srst,  // Sync reset
  input  wire logic d,     // Asynchronous level
  output logic      q      // Synchronised level
);
  logic meta_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sync2
`default_nettype wire

// file: rtl/tick_gen.sv
// Free running tick pulse generator
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
  parameter int DIV = 200000  // Cycles per tick
) (
  input  wire logic clk,   // System clock
  input  wire logic srst,  // Sync reset
  output logic      tick   // One-cycle pulse every DIV cycles
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_r;
  wire           wrap = (cnt_r == LAST);

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_r <= wrap ? '0 : cnt_r + CW'(1);
      tick  <= wrap;
    end
  end
endmodule : tick_gen
`default_nettype wire

// file: testbench/sdcm_props.sv
// Property checker for the step/direction current mode controller
`timescale 1ns/1ps
`default_nettype none
module sdcm_props
  import sdcm_pkg::*;
#(
  parameter int TICK_DIV = 4  // Cycles per idle tick
) (
  input wire logic        clk,          // Clock
  input wire logic        srst,         // Sync reset
  input wire logic [7:0]  reg_addr,     // Address
  input wire logic [15:0] reg_wdata,    // Write data
  input wire logic        reg_wr,       // Write strobe
  input wire logic        reg_rd,       // Read strobe
  input wire logic [15:0] reg_rdata,    // Read data
  input wire logic        enable_pin,   // Enable pin
  input wire logic        int_run_req,  // Internal run request
  input wire logic        int_drv_en,   // Internal driver enable
  input wire logic        sd_active,    // Step/dir active
  input wire logic        run_current,  // Run current
  input wire logic        drv_enable,   // Driver on
  input wire logic        coil_enable,  // Coils on
  input wire logic        step_pulse    // Step edge
);
  // ----------------------------------------------------------------
  // Shadow of the mode and of the time since the last step
  // ----------------------------------------------------------------
  // Two ticks of slack: the tick phase is free running
  localparam int IDLE_LIM = (int'(IDLE_TIME_RST) + 2) * TICK_DIV + 4;
  logic [2:0]  mode_r;
  logic [15:0] idle_r;
  wire         auto_w = mode_r == 3'h2 || mode_r == 3'h4;
  always_ff @(posedge clk) begin
    if (srst)
      mode_r <= MODE_RST;
    else if (reg_wr && reg_addr == ADDR_MODE && reg_wdata <= {13'h0, MODE_MAX})
      mode_r <= reg_wdata[2:0];
  end
  // Saturated value means no step seen yet, so no fallback is owed
  always_ff @(posedge clk) begin
    if (srst || !auto_w)
      idle_r <= 16'hffff;
    else if (step_pulse)
      idle_r <= 16'h0;
    else if (idle_r != 16'hffff)
      idle_r <= idle_r + 16'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_auto_step;
    auto_w && $past(auto_w) && step_pulse;
  endsequence
  chk_off_follows: assert property ((mode_r == 3'h0 && $stable(int_run_req) && $stable(int_drv_en))[*3]
    |-> run_current == int_run_req && drv_enable == int_drv_en) else $error("mode 0 outputs wrong");
  chk_active_mode: assert property (sd_active == ($past(mode_r) != 3'h0)) else $error("sd_active wrong");
  chk_sel_enable: assert property ((mode_r == 3'h1 && $stable(enable_pin))[*5]
    |-> run_current == enable_pin && drv_enable) else $error("mode 1 outputs wrong");
  chk_step_run: assert property (s_auto_step |-> ##[1:3] run_current) else $error("no run on step");
  chk_idle_hold: assert property (auto_w && idle_r == 16'(IDLE_LIM) |-> !run_current)
    else $error("no hold after idle");
  chk_ignore_en: assert property ($past(mode_r) == 3'h2 || $past(mode_r) == 3'h3
    |-> drv_enable && coil_enable) else $error("drivers off in mode 2 or 3");
  chk_run_always: assert property ($past(mode_r) == 3'h3 || $past(mode_r) == 3'h5 |-> run_current)
    else $error("hold in run mode");
  chk_stage_off: assert property ((mode_r[2] && !enable_pin)[*5] |-> !drv_enable && !coil_enable)
    else $error("stage not off");
  chk_stage_on: assert property ((mode_r[2] && enable_pin)[*5] |-> drv_enable && coil_enable)
    else $error("stage not on");
  chk_read_mode: assert property (reg_rd && reg_addr == ADDR_MODE |=> reg_rdata == {13'h0, $past(mode_r)})
    else $error("mode readback wrong");
endmodule : sdcm_props
bind step_dir_current_mode_ctrl sdcm_props #(.TICK_DIV(TICK_DIV)) i_props (.clk, .srst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .enable_pin, .int_run_req, .int_drv_en, .sd_active, .run_current, .drv_enable,
  .coil_enable, .step_pulse);
`default_nettype wire

// file: testbench/step_dir_current_mode_ctrl_test.sv
// Self-checking testbench for the step/direction current mode controller
`timescale 1ns/1ps
`default_nettype none
module step_dir_current_mode_ctrl_test;
  import sdcm_pkg::*;
  localparam int TDIV = 4;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        int_run_req = 1'b0;
  logic        int_drv_en = 1'b0;
  logic        go = 1'b0;
  logic [3:0]  width = 4'h1;
  logic        en_level = 1'b0;
  logic [15:0] reg_rdata;
  logic        step_pin, enable_pin, sd_active, run_current, drv_enable, coil_enable, step_pulse;
  logic        er, ed;
  int          err_count = 0;
  int          total_checks = 0;
  int          n;
  always #25 clk = ~clk;
  step_src i_src (.clk, .go, .width, .en_level, .step_pin, .enable_pin);
  step_dir_current_mode_ctrl #(.TICK_DIV(TDIV)) i_dut (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .step_pin, .enable_pin, .int_run_req, .int_drv_en, .sd_active, .run_current, .drv_enable,
    .coil_enable, .step_pulse);
  // ----------------------------------------------------------------
  // Access and checking tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rdchk
  task automatic finish_test;
    $display("Checks made %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rdchk(ADDR_MODE, 16'h0000);
    rdchk(ADDR_IDLE_TIME, IDLE_TIME_RST);
    rdchk(8'h00, 16'h0000);
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_MODE, 16'(m));
      rdchk(ADDR_MODE, 16'(m > 5 ? 5 : m));
    end
    for (int m = 0; m < 6; m++) begin
      for (int e = 0; e < 2; e++) begin
        en_level <= e[0];
        int_run_req <= e[0];
        int_drv_en <= !e[0];
        wr(ADDR_MODE, 16'(m));
        repeat (8) @(posedge clk);
        ed = (m == 0) ? !e[0] : (m >= 4) ? e[0] : 1'b1;
        er = (m == 3 || m == 5) ? 1'b1 : (m == 2 || m == 4) ? 1'b0 : e[0];
        #1 chk({13'h0, sd_active, coil_enable, drv_enable}, {13'h0, m != 0, ed, ed});
        chk(16'(run_current), 16'(er));
      end
    end
    // Mode 2 gets a prompt pulse, mode 4 a slow one
    for (int m = 2; m < 5; m += 2) begin
      wr(ADDR_MODE, 16'(m));
      @(posedge clk);
      width <= (m == 2) ? 4'h1 : 4'h9;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (16) @(posedge clk);
      #1 chk(16'(run_current), 16'h0001);
      n = 0;
      while (run_current === 1'b1 && n < 1000) begin
        @(posedge clk);
        #1 n++;
      end
      chk(16'(n >= 190 * TDIV && n < 1000), 16'h0001);
      if (n == 1000)
        finish_test;
    end
    finish_test;
  end
endmodule : step_dir_current_mode_ctrl_test
`default_nettype wire

// file: testbench/step_src.sv
// Step pulse and enable level source standing in for the external master
`timescale 1ns/1ps
`default_nettype none
module step_src (
  input  wire logic       clk,         // Clock
  input  wire logic       go,          // Start one step pulse
  input  wire logic [3:0] width,       // High cycles, 1 prompt, more slow
  input  wire logic       en_level,    // Requested enable level
  output logic            step_pin,    // Step output
  output logic            enable_pin   // Enable output
);
  logic [3:0] cnt_r = 4'h0;
  // Lines are push-pull driven, never released
  always_ff @(posedge clk) begin
    enable_pin <= en_level;
    if (go)
      cnt_r <= width;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end
  assign step_pin = cnt_r != 4'h0;
endmodule : step_src
`default_nettype wire
